// file: verilog/analog_io_scaling.sv
// How it works
// - primary input: 0 unipolar, 1 bipolar
// - primary and second inputs eleven bit
// - primary gain 0..1000.0 percent at 10V
// - primary bias plus minus 100 percent
// - second input: 0 unipolar, 1 bipolar
// - second input gain and bias likewise
// - function code routes input, 1F unused
// - current input: 0, 1, or 4-20mA
// - current input ten bit conversion
// - current input uses same function codes
// - current gain sets level at 20mA
// - current bias sets level at 4mA
// - common delay filter 0..2 seconds
// - first output monitor code 1..38
// - outputs nine bit magnitude plus sign
// - first output gain 0..2.50 multiplies
// - output is level times gain plus bias
// - second output uses same monitor codes
// - second output gain 0..2.50
// - one range select for both outputs
`timescale 1ns/1ps
`default_nettype none
module analog_io_scaling #(
  parameter int TICK_CYCLES = aio_pkg::FILT_STEP_NS / aio_pkg::MCLK_PERIOD_NS
) (
  input wire logic MCLK,
  input wire logic RST_B,
  input wire logic [10:0] PRIMARY_RAW,
  input wire logic [10:0] SECOND_RAW,
  input wire logic [9:0] CURRENT_RAW,
  input wire logic PRIMARY_INPUT_RANGE_SEL,
  input wire logic [13:0] PRIMARY_INPUT_GAIN,
  input wire logic signed [10:0] PRIMARY_INPUT_BIAS,
  input wire logic SECOND_INPUT_RANGE_SEL,
  input wire logic [4:0] SECOND_INPUT_FUNCTION_SEL,
  input wire logic [13:0] SECOND_INPUT_GAIN,
  input wire logic signed [10:0] SECOND_INPUT_BIAS,
  input wire logic [1:0] CURRENT_INPUT_RANGE_SEL,
  input wire logic [4:0] CURRENT_INPUT_FUNCTION_SEL,
  input wire logic [13:0] CURRENT_INPUT_GAIN,
  input wire logic signed [10:0] CURRENT_INPUT_BIAS,
  input wire logic [7:0] INPUT_FILTER_TIME,
  input wire logic [38:1][9:0] MON_LEVELS,
  input wire logic [5:0] FIRST_OUTPUT_MONITOR_SEL,
  input wire logic [7:0] FIRST_OUTPUT_GAIN,
  input wire logic signed [7:0] FIRST_OUTPUT_BIAS,
  input wire logic [5:0] SECOND_OUTPUT_MONITOR_SEL,
  input wire logic [7:0] SECOND_OUTPUT_GAIN,
  input wire logic signed [7:0] SECOND_OUTPUT_BIAS,
  input wire logic OUTPUT_RANGE_SEL,
  output aio_pkg::ain_res_t PRIMARY_RESULT,
  output aio_pkg::ain_res_t SECOND_RESULT,
  output aio_pkg::ain_res_t CURRENT_RESULT,
  output aio_pkg::aout_val_t FIRST_OUTPUT_VALUE,
  output aio_pkg::aout_val_t SECOND_OUTPUT_VALUE
);
  // ==========================================================
  // local sizes and state
  localparam int TCNT_W = $clog2(TICK_CYCLES);
  // magnitude reached by the top output bias at zero gain
  localparam logic [8:0] BIAS_TOP_MAG = 9'h033;

  // whole block state
  typedef struct packed {
    logic [TCNT_W-1:0] tick_cnt;
    logic tick;
    aio_pkg::ain_res_t [2:0] ain;
    aio_pkg::aout_val_t [1:0] aout;
  } state_t;

  state_t st_q; // registered state
  state_t st_d; // next state
  logic signed [11:0] norm [3]; // inputs before the filter
  logic signed [11:0] flt [3]; // inputs after the filter
  logic [7:0] tau; // clamped filter time
  logic signed [11:0] cur_off; // current above 4mA
  logic signed [24:0] cur_prod; // current span product

  // ==========================================================
  // pick the monitor level for an output code
  function automatic logic signed [9:0] pick_mon(input logic [5:0] sel);
    logic signed [9:0] m;
    m = '0;
    // unknown codes give a zero level
    if (sel >= aio_pkg::MON_LO && sel <= aio_pkg::MON_HI) begin
      if (aio_pkg::MON_MASK[sel]) begin
        m = $signed(MON_LEVELS[sel]);
      end
    end
    // own input levels are monitored after the filter, halved
    if (sel == aio_pkg::MON_T13) begin
      m = 10'(flt[0] >>> 1);
    end else if (sel == aio_pkg::MON_T14) begin
      m = 10'(flt[2] >>> 1);
    end else if (sel == aio_pkg::MON_T16) begin
      m = 10'(flt[1] >>> 1);
    end
    return m;
  endfunction

  // ==========================================================
  // input normalisation to 10 V = 1024
  always_comb begin
    if (PRIMARY_INPUT_RANGE_SEL) begin
      norm[0] = {PRIMARY_RAW[10], PRIMARY_RAW};
    end else begin
      norm[0] = {2'b00, PRIMARY_RAW[10:1]};
    end
    if (SECOND_INPUT_RANGE_SEL) begin
      norm[1] = {SECOND_RAW[10], SECOND_RAW};
    end else begin
      norm[1] = {2'b00, SECOND_RAW[10:1]};
    end
    cur_off = $signed({2'b00, CURRENT_RAW}) - $signed({2'b00, aio_pkg::CUR_4MA});
    cur_prod = 25'(cur_off) * 25'($signed({1'b0, aio_pkg::CUR_SPAN_K}));
    unique case (CURRENT_INPUT_RANGE_SEL)
      aio_pkg::RANGE_UNI: begin
        norm[2] = {2'b00, CURRENT_RAW};
      end
      aio_pkg::RANGE_BI: begin
        norm[2] = {CURRENT_RAW[9], CURRENT_RAW, 1'b0};
      end
      default: begin
        // 20mA maps to full scale, below 4mA reads zero
        norm[2] = cur_off[11] ? 12'sh000 : 12'(cur_prod >>> aio_pkg::NORM_SHIFT);
      end
    endcase
  end

  // filter time beyond the range is held at the top
  assign tau = (INPUT_FILTER_TIME > aio_pkg::FILT_MAX) ? aio_pkg::FILT_MAX : INPUT_FILTER_TIME;

  // ==========================================================
  // one delay filter per input, shared time and step
  for (genvar i = 0; i < 3; i++) begin : g_filt
    lag_filter u_filt (
      .clk(MCLK),
      .rst_b(RST_B),
      .tick(st_q.tick),
      .tau(tau),
      .x(norm[i]),
      .y(flt[i])
    );
  end

  // ==========================================================
  // next state: filter step, scaled inputs, outputs
  always_comb begin
    st_d = st_q;
    // filter step strobe every 10 ms
    st_d.tick = 1'b0;
    if (st_q.tick_cnt == TCNT_W'(TICK_CYCLES - 1)) begin
      st_d.tick_cnt = '0;
      st_d.tick = 1'b1;
    end else begin
      st_d.tick_cnt = st_q.tick_cnt + 1'b1;
    end
    st_d.ain[0].level = aio_pkg::scale_in(flt[0], PRIMARY_INPUT_GAIN, PRIMARY_INPUT_BIAS);
    st_d.ain[0].func = aio_pkg::FUNC_AUX;
    st_d.ain[0].used = 1'b1;
    st_d.ain[1].level = aio_pkg::scale_in(flt[1], SECOND_INPUT_GAIN, SECOND_INPUT_BIAS);
    st_d.ain[1].used = aio_pkg::func_legal(SECOND_INPUT_FUNCTION_SEL);
    if (st_d.ain[1].used) begin
      st_d.ain[1].func = SECOND_INPUT_FUNCTION_SEL;
    end else begin
      st_d.ain[1].func = aio_pkg::FUNC_UNUSED;
    end
    st_d.ain[2].level = aio_pkg::scale_in(flt[2], CURRENT_INPUT_GAIN, CURRENT_INPUT_BIAS);
    st_d.ain[2].used = aio_pkg::func_legal(CURRENT_INPUT_FUNCTION_SEL);
    if (st_d.ain[2].used) begin
      st_d.ain[2].func = CURRENT_INPUT_FUNCTION_SEL;
    end else begin
      st_d.ain[2].func = aio_pkg::FUNC_UNUSED;
    end
    st_d.aout[0] = aio_pkg::ao_calc(pick_mon(FIRST_OUTPUT_MONITOR_SEL),
        FIRST_OUTPUT_GAIN, FIRST_OUTPUT_BIAS, OUTPUT_RANGE_SEL);
    st_d.aout[1] = aio_pkg::ao_calc(pick_mon(SECOND_OUTPUT_MONITOR_SEL),
        SECOND_OUTPUT_GAIN, SECOND_OUTPUT_BIAS, OUTPUT_RANGE_SEL);
  end

  // ==========================================================
  // state register
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // outputs straight from flops
  assign PRIMARY_RESULT = st_q.ain[0];
  assign SECOND_RESULT = st_q.ain[1];
  assign CURRENT_RESULT = st_q.ain[2];
  assign FIRST_OUTPUT_VALUE = st_q.aout[0];
  assign SECOND_OUTPUT_VALUE = st_q.aout[1];

  // ==========================================================
  // checks
  // unused code gives no function
  property p_unused;
    @(posedge MCLK) disable iff (!RST_B)
    SECOND_INPUT_FUNCTION_SEL == aio_pkg::FUNC_UNUSED
      |=> !SECOND_RESULT.used && SECOND_RESULT.func == aio_pkg::FUNC_UNUSED;
  endproperty
  a_unused: assert property (p_unused) else $error("unused code routed");

  property p_same_code;
    @(posedge MCLK) disable iff (!RST_B)
    CURRENT_INPUT_FUNCTION_SEL == SECOND_INPUT_FUNCTION_SEL
      |=> CURRENT_RESULT.used == SECOND_RESULT.used
          && CURRENT_RESULT.func == SECOND_RESULT.func;
  endproperty
  a_same_code: assert property (p_same_code) else $error("code decode differs");

  property p_uni_out;
    @(posedge MCLK) disable iff (!RST_B)
    OUTPUT_RANGE_SEL == 1'b0
      |=> !FIRST_OUTPUT_VALUE.neg && !SECOND_OUTPUT_VALUE.neg;
  endproperty
  a_uni_out: assert property (p_uni_out) else $error("negative in unipolar range");

  property p_mon_zero;
    @(posedge MCLK) disable iff (!RST_B)
    FIRST_OUTPUT_MONITOR_SEL == '0 && FIRST_OUTPUT_BIAS == '0
      |=> FIRST_OUTPUT_VALUE == '0;
  endproperty
  a_mon_zero: assert property (p_mon_zero) else $error("unknown monitor not zero");

  // top bias alone sets the level
  property p_ao_bias;
    @(posedge MCLK) disable iff (!RST_B)
    FIRST_OUTPUT_GAIN == '0 && FIRST_OUTPUT_BIAS == aio_pkg::AO_BIAS_LIM
      |=> !FIRST_OUTPUT_VALUE.neg && FIRST_OUTPUT_VALUE.mag == BIAS_TOP_MAG;
  endproperty
  a_ao_bias: assert property (p_ao_bias) else $error("output bias wrong");

  // zero gain leaves the bias alone
  property p_zero_gain;
    @(posedge MCLK) disable iff (!RST_B)
    PRIMARY_INPUT_GAIN == '0 && PRIMARY_INPUT_BIAS == aio_pkg::BIAS_LIM
      |=> PRIMARY_RESULT.level == 16'(aio_pkg::BIAS_LIM);
  endproperty
  a_zero_gain: assert property (p_zero_gain) else $error("input bias wrong");

  // current below 4mA, filter off, two cycles
  sequence s_cur_low;
    (CURRENT_INPUT_RANGE_SEL == aio_pkg::RANGE_CUR && CURRENT_RAW < aio_pkg::CUR_4MA
      && INPUT_FILTER_TIME == '0) [*2];
  endsequence
  // below 4mA the level is the bias
  property p_cur_low;
    @(posedge MCLK) disable iff (!RST_B)
    s_cur_low ##0 (CURRENT_INPUT_BIAS == '0) |=> CURRENT_RESULT.level == '0;
  endproperty
  a_cur_low: assert property (p_cur_low) else $error("loop under 4mA not zero");

  // input level held within plus minus 1000 percent
  property p_sat;
    @(posedge MCLK) disable iff (!RST_B)
    $signed(PRIMARY_RESULT.level) <= 16'(aio_pkg::LEVEL_SAT)
      && $signed(PRIMARY_RESULT.level) >= -16'(aio_pkg::LEVEL_SAT);
  endproperty
  a_sat: assert property (p_sat) else $error("input level wrapped");
endmodule // analog_io_scaling
`default_nettype wire

// file: common/aio_pkg.sv
package aio_pkg;
  // ==========================================================
  // input side: normalised level, 10 V full scale = 1024
  localparam int NORM_SHIFT = 10;
  localparam logic [1:0] RANGE_UNI = 2'h0;
  localparam logic [1:0] RANGE_BI = 2'h1;
  localparam logic [1:0] RANGE_CUR = 2'h2;
  localparam logic [4:0] FUNC_AUX = 5'h00;
  localparam logic [4:0] FUNC_LAST = 5'h15;
  localparam logic [4:0] FUNC_HOLE0 = 5'h03;
  localparam logic [4:0] FUNC_HOLE1 = 5'h0e;
  localparam logic [4:0] FUNC_HOLE2 = 5'h0f;
  localparam logic [4:0] FUNC_UNUSED = 5'h1f;
  localparam logic [13:0] GAIN_MAX = 14'h2710;
  localparam logic signed [10:0] BIAS_LIM = 11'sh3e8;
  localparam logic signed [16:0] LEVEL_SAT = 17'sh02710;
  localparam logic [9:0] CUR_4MA = 10'h0cd;
  localparam logic [12:0] CUR_SPAN_K = 13'h0500;
  // ==========================================================
  // delay filter: tau in steps of 10 ms
  localparam logic [7:0] FILT_MAX = 8'hc8;
  localparam int FILT_FRAC = 16;
  localparam int FILT_STEP_NS = 10000000;
  localparam int MCLK_PERIOD_NS = 4;
  localparam int DIV_STEPS = 29;
  // ==========================================================
  // output side: 9 bit magnitude, 10 V = 511
  localparam logic [5:0] MON_LO = 6'h01;
  localparam logic [5:0] MON_HI = 6'h26;
  localparam logic [5:0] MON_T13 = 6'h0f;
  localparam logic [5:0] MON_T14 = 6'h10;
  localparam logic [5:0] MON_T16 = 6'h11;
  localparam logic [38:0] MON_MASK = 39'h73_0dff_83ee;
  localparam logic signed [31:0] AO_FULL = 32'sh0000_01ff;
  localparam logic [7:0] AO_GAIN_MAX = 8'hfa;
  localparam logic signed [7:0] AO_BIAS_LIM = 8'sh64;
  localparam logic [12:0] AO_GAIN_K = 13'h0029;
  localparam int AO_GAIN_SH = 12;
  localparam logic [8:0] AO_BIAS_K = 9'h083;
  localparam int AO_BIAS_SH = 8;

  // scaled input result
  typedef struct packed {
    logic signed [15:0] level;
    logic [4:0] func;
    logic used;
  } ain_res_t;

  // analog output code, sign and magnitude
  typedef struct packed {
    logic neg;
    logic [8:0] mag;
  } aout_val_t;

  // ==========================================================
  // function code decode shared by both multi-function inputs
  function automatic logic func_legal(input logic [4:0] c);
    return (c <= FUNC_LAST) && (c != FUNC_HOLE0) && (c != FUNC_HOLE1) && (c != FUNC_HOLE2);
  endfunction

  // gain and bias on a normalised input, saturating
  function automatic logic signed [15:0] scale_in(input logic signed [11:0] f,
      input logic [13:0] gain, input logic signed [10:0] bias);
    logic [13:0] g;
    logic signed [10:0] b;
    logic signed [26:0] p;
    logic signed [16:0] s;
    g = (gain > GAIN_MAX) ? GAIN_MAX : gain;
    b = (bias > BIAS_LIM) ? BIAS_LIM : ((bias < -BIAS_LIM) ? -BIAS_LIM : bias);
    p = 27'(f) * 27'($signed({1'b0, g}));
    s = 17'(p >>> NORM_SHIFT) + 17'(b);
    if (s > LEVEL_SAT) s = LEVEL_SAT;
    if (s < -LEVEL_SAT) s = -LEVEL_SAT;
    return 16'(s);
  endfunction

  // monitor times gain plus bias, clamped to the output range
  function automatic aout_val_t ao_calc(input logic signed [9:0] m,
      input logic [7:0] gain, input logic signed [7:0] bias, input logic bi);
    logic [7:0] g;
    logic signed [7:0] b;
    logic signed [31:0] s;
    logic signed [31:0] lo;
    aout_val_t v;
    g = (gain > AO_GAIN_MAX) ? AO_GAIN_MAX : gain;
    b = (bias > AO_BIAS_LIM) ? AO_BIAS_LIM : ((bias < -AO_BIAS_LIM) ? -AO_BIAS_LIM : bias);
    s = (32'(m) * $signed({1'b0, g}) * $signed({1'b0, AO_GAIN_K})) >>> AO_GAIN_SH;
    s = s + ((32'(b) * $signed({1'b0, AO_BIAS_K})) >>> AO_BIAS_SH);
    lo = bi ? -AO_FULL : 32'sh0;
    if (s > AO_FULL) s = AO_FULL;
    if (s < lo) s = lo;
    v.neg = s[31];
    v.mag = s[31] ? 9'(-s) : 9'(s);
    return v;
  endfunction
endpackage

// file: verilog/lag_filter.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// first-order lag: each step y += (x - y) / tau, tau 0 = bypass
module lag_filter (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic tick,
  input wire logic [7:0] tau,
  input wire logic signed [11:0] x,
  output logic signed [11:0] y
);
  typedef enum logic [1:0] {PH_IDLE, PH_DIV, PH_ADD} phase_t;
  // whole filter state
  typedef struct packed {
    phase_t phase;
    logic signed [27:0] acc;
    logic [28:0] num;
    logic [7:0] rem;
    logic [4:0] step;
    logic neg;
    logic signed [11:0] y;
  } fstate_t;
  fstate_t st_q, st_d;
  logic signed [28:0] diff;
  logic [8:0] r;

  // ==========================================================
  // next state: bypass, start, divide bit by bit, accumulate
  always_comb begin
    st_d = st_q;
    r = '0;
    diff = $signed({x[11], x, 16'h0000}) - 29'(st_q.acc);
    unique case (st_q.phase)
      PH_IDLE: begin
        if (tick) begin
          st_d.phase = PH_DIV;
          st_d.neg = diff[28];
          st_d.num = diff[28] ? 29'(-diff) : 29'(diff);
          st_d.rem = '0;
          st_d.step = '0;
        end
      end
      PH_DIV: begin
        // restoring divide, one quotient bit a cycle
        r = {st_q.rem, st_q.num[28]};
        st_d.num = {st_q.num[27:0], 1'b0};
        if (r >= {1'b0, tau}) begin
          r = r - {1'b0, tau};
          st_d.num[0] = 1'b1;
        end
        st_d.rem = r[7:0];
        st_d.step = st_q.step + 5'h01;
        if (st_q.step == 5'(aio_pkg::DIV_STEPS - 1)) st_d.phase = PH_ADD;
      end
      PH_ADD: begin
        st_d.acc = st_q.neg ? st_q.acc - 28'(st_q.num) : st_q.acc + 28'(st_q.num);
        st_d.phase = PH_IDLE;
      end
    endcase
    if (tau == '0) begin
      st_d.acc = {x, 16'h0000};
      st_d.phase = PH_IDLE;
    end
    st_d.y = st_d.acc[27:16];
  end

  // state register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign y = st_q.y;

  property p_step_time;
    @(posedge clk) disable iff (!rst_b)
    (tick && tau != '0 && st_q.phase == PH_IDLE && $stable(tau) && tau != '0)
      |=> ##29 (st_q.phase == PH_ADD || tau == '0);
  endproperty
  a_step_time: assert property (p_step_time) else $error("filter step late");
endmodule // lag_filter
`default_nettype wire

// file: test/analog_field.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// field side: voltage and current sources plus the drive's own
// monitor quantities, held steady as levels between bench updates
module analog_field (
  input wire logic [10:0] p_want,
  input wire logic [10:0] s_want,
  input wire logic [9:0] c_want,
  input wire logic [38:1][9:0] mon_want,
  output logic [10:0] p_raw,
  output logic [10:0] s_raw,
  output logic [9:0] c_raw,
  output logic [38:1][9:0] mon_raw
);
  // sources settle at once, converter codes follow the wanted levels
  assign p_raw = p_want;
  assign s_raw = s_want;
  assign c_raw = c_want;
  assign mon_raw = mon_want;
endmodule // analog_field
`default_nettype wire

// file: test/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ============================================================
  // clock, reset and stimulus
  logic MCLK = 1'b0;
  logic RST_B = 1'b0;
  integer seed = 32'hf9d8c997;
  int error_cnt = 0;
  int num_checks = 0;
  logic [10:0] p_want = 11'h000, s_want = 11'h000, p_raw, s_raw;
  logic [9:0] c_want = 10'h000, c_raw;
  logic [38:1][9:0] mon_want = '0, mon_raw;
  logic p_rs = 1'b0, s_rs = 1'b0, o_rs = 1'b0;
  logic [1:0] c_rs = 2'h2;
  logic [13:0] p_gain = 14'h03e8, s_gain = 14'h03e8, c_gain = 14'h03e8;
  logic signed [10:0] p_bias = 11'sh000, s_bias = 11'sh000, c_bias = 11'sh000;
  logic [4:0] s_fn = 5'h00, c_fn = 5'h00;
  logic [7:0] tau = 8'h00, o1_gain = 8'h64, o2_gain = 8'h64;
  logic signed [7:0] o1_bias = 8'sh00, o2_bias = 8'sh00;
  logic [5:0] o1_sel = 6'h02, o2_sel = 6'h02;
  aio_pkg::ain_res_t PRIMARY_RESULT, SECOND_RESULT, CURRENT_RESULT;
  aio_pkg::aout_val_t FIRST_OUTPUT_VALUE, SECOND_OUTPUT_VALUE;

  // free running clock, 4 ns period
  always #2 MCLK = ~MCLK;

  analog_field analog_field_inst (
    .p_want(p_want), .s_want(s_want), .c_want(c_want), .mon_want(mon_want),
    .p_raw(p_raw), .s_raw(s_raw), .c_raw(c_raw), .mon_raw(mon_raw)
  );

  // short filter step so the lag is seen within a few hundred cycles
  analog_io_scaling #(.TICK_CYCLES(64)) analog_io_scaling_inst (
    .MCLK(MCLK), .RST_B(RST_B), .PRIMARY_RAW(p_raw), .SECOND_RAW(s_raw),
    .CURRENT_RAW(c_raw), .PRIMARY_INPUT_RANGE_SEL(p_rs), .PRIMARY_INPUT_GAIN(p_gain),
    .PRIMARY_INPUT_BIAS(p_bias), .SECOND_INPUT_RANGE_SEL(s_rs),
    .SECOND_INPUT_FUNCTION_SEL(s_fn), .SECOND_INPUT_GAIN(s_gain),
    .SECOND_INPUT_BIAS(s_bias), .CURRENT_INPUT_RANGE_SEL(c_rs),
    .CURRENT_INPUT_FUNCTION_SEL(c_fn), .CURRENT_INPUT_GAIN(c_gain),
    .CURRENT_INPUT_BIAS(c_bias), .INPUT_FILTER_TIME(tau), .MON_LEVELS(mon_raw),
    .FIRST_OUTPUT_MONITOR_SEL(o1_sel), .FIRST_OUTPUT_GAIN(o1_gain),
    .FIRST_OUTPUT_BIAS(o1_bias), .SECOND_OUTPUT_MONITOR_SEL(o2_sel),
    .SECOND_OUTPUT_GAIN(o2_gain), .SECOND_OUTPUT_BIAS(o2_bias),
    .OUTPUT_RANGE_SEL(o_rs), .PRIMARY_RESULT(PRIMARY_RESULT),
    .SECOND_RESULT(SECOND_RESULT), .CURRENT_RESULT(CURRENT_RESULT),
    .FIRST_OUTPUT_VALUE(FIRST_OUTPUT_VALUE), .SECOND_OUTPUT_VALUE(SECOND_OUTPUT_VALUE)
  );

  // ============================================================
  // expectation functions
  // voltage input normalised so that 10 V reads 1024
  function automatic int f_volt(input logic [10:0] raw, input logic bi);
    if (bi) begin
      return int'($signed(raw));
    end
    return int'(raw) >>> 1;
  endfunction

  // current-capable input: two voltage ranges or the 4-20 mA loop
  function automatic int f_cur(input logic [9:0] raw, input logic [1:0] rs);
    if (rs == 2'h0) begin
      return int'(raw);
    end
    if (rs == 2'h1) begin
      return int'($signed(raw)) * 2;
    end
    if (raw < 10'h0cd) begin
      return 0;
    end
    return ((int'(raw) - 205) * 1280) >>> 10;
  endfunction

  // monitor level a code selects: own inputs halved, unknown codes zero
  function automatic int exp_mon(input logic [5:0] sel);
    if (sel == 6'h0f) begin
      return f_volt(p_want, p_rs) >>> 1;
    end
    if (sel == 6'h10) begin
      return f_cur(c_want, c_rs) >>> 1;
    end
    if (sel == 6'h11) begin
      return f_volt(s_want, s_rs) >>> 1;
    end
    if (sel >= 6'h01 && sel <= 6'h26 && aio_pkg::MON_MASK[sel]) begin
      return int'($signed(mon_want[sel]));
    end
    return 0;
  endfunction

  // gain and bias in 0.1 %, saturated, plus the function routing fields
  function automatic logic [21:0] exp_in(input int f, input int g, input int b,
      input logic [4:0] fc, input bit prim);
    int s;
    logic [4:0] ef;
    logic eu;
    if (g > 10000) g = 10000;
    if (b > 1000) b = 1000;
    if (b < -1000) b = -1000;
    s = ((f * g) >>> 10) + b;
    if (s > 10000) s = 10000;
    if (s < -10000) s = -10000;
    // holes in the code list and codes above 15 hex read as unused
    if (fc <= 5'h15 && fc != 5'h03 && fc != 5'h0e && fc != 5'h0f) begin
      ef = fc;
      eu = 1'b1;
    end else begin
      ef = 5'h1f;
      eu = 1'b0;
    end
    if (prim) begin
      ef = 5'h00;
      eu = 1'b1;
    end
    return {s[15:0], ef, eu};
  endfunction

  // monitor times gain plus bias, clamped to the chosen output range
  function automatic logic [9:0] exp_out(input int m, input int g, input int b, input bit bi);
    int s;
    if (g > 250) g = 250;
    if (b > 100) b = 100;
    if (b < -100) b = -100;
    s = ((m * g * 41) >>> 12) + ((b * 131) >>> 8);
    if (s > 511) s = 511;
    if (s < (bi ? -511 : 0)) s = bi ? -511 : 0;
    return {s < 0, 9'(s < 0 ? -s : s)};
  endfunction

  // ============================================================
  // compare and report
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // let raw and settings pass the filter flop and the result flop
  task automatic chk_inputs;
    repeat (3) @(negedge MCLK);
    chk("primary", PRIMARY_RESULT, exp_in(f_volt(p_want, p_rs), p_gain, p_bias, 5'h00, 1));
    chk("second", SECOND_RESULT, exp_in(f_volt(s_want, s_rs), s_gain, s_bias, s_fn, 0));
    chk("current", CURRENT_RESULT, exp_in(f_cur(c_want, c_rs), c_gain, c_bias, c_fn, 0));
  endtask

  // monitor path answers one edge after its inputs
  task automatic chk_outputs;
    repeat (2) @(negedge MCLK);
    chk("out1", FIRST_OUTPUT_VALUE, exp_out(exp_mon(o1_sel), o1_gain, o1_bias, o_rs));
    chk("out2", SECOND_OUTPUT_VALUE, exp_out(exp_mon(o2_sel), o2_gain, o2_bias, o_rs));
  endtask

  // ============================================================
  // watchdog cuts a hang short
  initial begin
    #100000;
    error_cnt++;
    test_done();
  end

  // ============================================================
  // main sequence
  initial begin
    int k;
    repeat (2) @(posedge MCLK);
    @(negedge MCLK);
    RST_B = 1'b1;
    // full scale unipolar at unity gain, no filter
    p_want = 11'h7ff;
    chk_inputs();
    // saturation corners: primary at bipolar top, second at bipolar bottom, maximum gain and bias of each sign
    p_rs = 1'b1;
    s_rs = 1'b1;
    p_want = 11'h3ff;
    s_want = 11'h400;
    p_gain = 14'h2710;
    s_gain = 14'h3fff;
    p_bias = 11'sh3e8;
    s_bias = -11'sh3e8;
    chk_inputs();
    // zero gain leaves the bias alone
    p_gain = 14'h0000;
    chk_inputs();
    // every function code and every current range, just below and above 4 mA
    for (k = 0; k < 32; k++) begin
      s_fn = 5'(k);
      c_fn = 5'(31 - k);
      c_rs = 2'(k);
      c_want = k[2] ? 10'h0cc : 10'h0ce + 10'(k);
      chk_inputs();
    end
    // random levels and settings
    for (k = 0; k < 40; k++) begin
      p_want = 11'($random(seed));
      s_want = 11'($random(seed));
      c_want = 10'($random(seed));
      {p_rs, s_rs, c_rs} = 4'($random(seed));
      p_gain = 14'($random(seed));
      s_gain = 14'($random(seed));
      c_gain = 14'($random(seed));
      p_bias = 11'($random(seed));
      s_bias = 11'($random(seed));
      c_bias = 11'($random(seed));
      s_fn = 5'($random(seed));
      c_fn = 5'($random(seed));
      chk_inputs();
    end
    // every monitor code on both outputs, own inputs and unknown codes too
    for (k = 0; k < 40; k++) begin
      if (k >= 1 && k <= 38) begin
        mon_want[k] = 10'($random(seed));
      end
      o1_sel = 6'(k);
      o2_sel = 6'(39 - k);
      o1_gain = 8'($random(seed));
      o2_gain = 8'($random(seed));
      o1_bias = (k == 0) ? 8'sh00 : 8'($random(seed));
      o2_bias = 8'($random(seed));
      o_rs = k[0];
      chk_outputs();
    end
    // output clamp at top and at zero in the unipolar range
    mon_want[2] = 10'h1ff;
    mon_want[3] = 10'h200;
    o1_sel = 6'h02;
    o2_sel = 6'h03;
    o1_gain = 8'hfa;
    o2_gain = 8'hfa;
    o1_bias = 8'sh64;
    o2_bias = 8'sh00;
    o_rs = 1'b0;
    chk_outputs();
    // top bias alone at zero gain
    o1_gain = 8'h00;
    chk_outputs();
    // second reset in mid-run clears both outputs and the primary result
    RST_B = 1'b0;
    @(negedge MCLK);
    chk("rst_out", {FIRST_OUTPUT_VALUE, SECOND_OUTPUT_VALUE}, 32'h0);
    chk("rst_in", PRIMARY_RESULT, 32'h0);
    // lag of one step: level holds at zero until the first filter step
    tau = 8'h01;
    p_rs = 1'b0;
    p_want = 11'h7ff;
    p_gain = 14'h03e8;
    p_bias = 11'sh000;
    @(negedge MCLK);
    RST_B = 1'b1;
    repeat (20) @(negedge MCLK);
    chk("lag_early", PRIMARY_RESULT.level, 32'h0);
    repeat (80) @(negedge MCLK);
    chk("lag_late", PRIMARY_RESULT.level, 32'd999);
    test_done();
  end
endmodule // tb
`default_nettype wire
